// ===== pbtc_core.sv
// Bridge tuning controls: AHB-Lite registers and PCI-side timers
//
// Our own choices: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
//
// How it works
// - Flushing: request read at flush threshold
// - Prefetch count hits read threshold: request
// - Reserved fields read back zero
// - Count outbound retries, abort past limit
// - Retry code 0 unlimited, else 8..512
// - Subsequent data late: terminate, 8/4 edges
// - First data late: terminate, 32..4 edges
// - Usage time-out limits bus tenure
// - Latency timer low three bits zero
// - IDE prefetch halts one dword early
// - Next sector read resumes IDE prefetch
// - Sector size in 64-byte units, 0 off
// - Sustain clocks after busy drops
// - Sustain code 0 none, else 4..256
module pbtc_core
  import pbtc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic busyIn,
  output logic clkRunReq,
  input wire logic pciClk,
  input wire logic tgtStart,
  input wire logic tgtDataRdy,
  input wire logic tgtEnd,
  output logic tgtStop,
  input wire logic mstStart,
  input wire logic mstRetry,
  input wire logic mstDone,
  output logic mstAbort,
  input wire logic mstTenure,
  input wire logic mstGnt,
  input wire logic mstBoundary,
  output logic tenureEnd,
  input wire logic pfFill,
  input wire logic pfConsume,
  input wire logic flushActive,
  output logic readReq,
  input wire logic idePrefetch,
  input wire logic ideRead,
  output logic idePrefetchOk
);

  // Register select from the low address bits
  function automatic logic [1:0] reg_sel(input logic [31:0] a);
    case (a[11:0])
      CTRL_LO_OFS: return SEL_LO;
      CTRL_HI_OFS: return SEL_HI;
      STATUS_OFS: return SEL_STAT;
      default: return SEL_NONE;
    endcase
  endfunction

  // Fabric-clock state
  typedef struct packed {
    logic [31:0] ctlHi;
    logic [31:0] ctlLo;
    logic wrPend;
    logic [1:0] wrSel;
    logic [31:0] rdata;
    logic [8:0] susCnt;
    logic run;
    logic [1:0] bsySy;
    logic [1:0] hltSy;
  } pbtc_sys_t;

  // PCI-clock state
  typedef struct packed {
    pbtc_tst_t st;
    logic [5:0] latCnt;
    logic stop;
    logic [9:0] rty;
    logic abort;
    logic [7:0] useCnt;
    logic useDone;
    logic endTen;
    logic [5:0] pfCnt;
    logic rdReq;
    logic [11:0] idePf;
    logic [11:0] ideRd;
    logic ideWait;
    logic pfOk;
    logic busy;
  } pbtc_pci_t;

  pbtc_sys_t s, sNxt;
  pbtc_pci_t p, pNxt;

  logic addrPhase; // Valid address phase seen
  logic [63:0] cfg; // Control word in the PCI domain
  logic [31:0] cfgHi;
  logic [31:0] cfgLo;
  logic [5:0] initLim; // Edges allowed before first data
  logic [5:0] subsLim; // Edges allowed between data phases
  logic [5:0] curLim;
  logic [9:0] rtyLim;
  logic [7:0] useLim; // Latency compare value, low bits zero
  logic [11:0] secDw; // Sector length in dwords
  logic [11:0] lastPf;
  logic [3:0] thr;

  ////////////////////////////////////////////////////////////////////
  // Bus slave answers at once and always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = s.rdata;
  assign clkRunReq = s.run;
  assign addrPhase = hsel & hready & htrans[1];

  // Registers, read data and clock sustain
  always_comb begin
    sNxt = s;
    // Data phase of a write; only implemented bits stored
    if (s.wrPend) begin
      case (s.wrSel)
        SEL_LO: sNxt.ctlLo = hwdata & CTRL_LO_MASK;
        SEL_HI: sNxt.ctlHi = hwdata & CTRL_HI_MASK;
        default: sNxt.ctlLo = s.ctlLo;
      endcase
    end
    sNxt.wrPend = addrPhase & hwrite;
    sNxt.wrSel = reg_sel(haddr);
    // Read data from the updated copy, so back-to-back works
    if (addrPhase && !hwrite) begin
      case (reg_sel(haddr))
        SEL_LO: sNxt.rdata = sNxt.ctlLo & CTRL_LO_MASK;
        SEL_HI: sNxt.rdata = sNxt.ctlHi & CTRL_HI_MASK;
        SEL_STAT: sNxt.rdata = {29'h0, s.hltSy[1], s.bsySy[1], s.run};
        default: sNxt.rdata = 32'h0;
      endcase
    end
    // Level crossings from the PCI side
    sNxt.bsySy = {s.bsySy[0], p.busy};
    sNxt.hltSy = {s.hltSy[0], ~p.pfOk};
    // Sustain reloads while busy, then counts down
    if (busyIn || s.bsySy[1]) begin
      sNxt.susCnt = pbtc_sus_len(s.ctlLo[SUS_LSB +: 3]);
    end else if (s.susCnt != 9'h0) begin
      sNxt.susCnt = s.susCnt - 9'h1;
    end
    // Old count, so every code holds one cycle past its decode
    sNxt.run = busyIn | s.bsySy[1] | (s.susCnt != 9'h0);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '{ctlHi: CTRL_HI_RST & CTRL_HI_MASK,
             ctlLo: CTRL_LO_RST & CTRL_LO_MASK,
             wrSel: SEL_NONE, default: '0};
    end else begin
      s <= sNxt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Control word crosses by handshake; fields are quasi-static
  pbtc_cdc_word #(
    .W(64),
    .RST({CTRL_HI_RST & CTRL_HI_MASK, CTRL_LO_RST & CTRL_LO_MASK})
  ) uCfg (
    .srcClk(clk),
    .dstClk(pciClk),
    .rst_n(rst_n),
    .srcData({s.ctlHi, s.ctlLo}),
    .dstData(cfg)
  );

  assign cfgHi = cfg[63:32];
  assign cfgLo = cfg[31:0];
  assign initLim = INITIAL_LATENCY_TIMEOUT_MAX >> cfgHi[INITIAL_LATENCY_TIMEOUT_LSB +: 2];
  assign subsLim = cfgHi[SUBSEQUENT_LATENCY_TIMEOUT_BIT] ? SUBSEQUENT_LATENCY_TIMEOUT_FAST : SUBSEQUENT_LATENCY_TIMEOUT_SLOW;
  assign curLim = (p.st == TS_FIRST) ? initLim : subsLim;
  assign rtyLim = pbtc_rty_lim(cfgHi[RTL_LSB +: 3]);
  assign useLim = {cfgHi[LAT_LSB +: 5], 3'h0};
  assign secDw = {cfgLo[SEC_LSB +: 8], 4'h0};
  assign lastPf = secDw - 12'h1;
  assign thr = flushActive ? cfgHi[FTH_LSB +: 4]
                           : cfgHi[RTH_LSB +: 4];

  assign tgtStop = p.stop;
  assign mstAbort = p.abort;
  assign tenureEnd = p.endTen;
  assign readReq = p.rdReq;
  assign idePrefetchOk = p.pfOk;

  ////////////////////////////////////////////////////////////////////
  // PCI-side timers and counters
  always_comb begin
    logic [5:0] pfAfter;
    pfAfter = 6'h0;
    pNxt = p;
    pNxt.stop = 1'b0;
    pNxt.abort = 1'b0;
    pNxt.endTen = 1'b0;
    pNxt.rdReq = 1'b0;

    // Target latency: count edges without a data phase
    case (p.st)
      TS_IDLE: begin
        if (tgtStart) begin
          pNxt.st = TS_FIRST;
          pNxt.latCnt = 6'h0;
        end
      end
      TS_FIRST, TS_BURST: begin
        if (tgtEnd) begin
          pNxt.st = TS_IDLE;
        end else if (tgtDataRdy) begin
          pNxt.st = TS_BURST;
          pNxt.latCnt = 6'h0;
        end else if (p.latCnt + 6'h1 == curLim) begin
          pNxt.stop = 1'b1;
          pNxt.st = TS_STOP;
        end else begin
          pNxt.latCnt = p.latCnt + 6'h1;
        end
      end
      TS_STOP: pNxt.st = TS_IDLE;
      default: pNxt.st = TS_IDLE;
    endcase

    // Outbound retries; abort once the count passes the limit
    if (mstStart || mstDone) begin
      pNxt.rty = 10'h0;
    end else if (mstRetry) begin
      if (rtyLim != 10'h0 && p.rty == rtyLim) begin
        pNxt.abort = 1'b1;
        pNxt.rty = 10'h0;
      end else if (p.rty != 10'h3ff) begin
        pNxt.rty = p.rty + 10'h1;
      end
    end

    // Usage timer runs in clocks, compared in units of eight
    if (!mstTenure) begin
      pNxt.useCnt = 8'h0;
      pNxt.useDone = 1'b0;
    end else begin
      if (p.useCnt != 8'hff) begin
        pNxt.useCnt = p.useCnt + 8'h1;
      end
      // Only leave at a boundary, and only without grant
      if (p.useCnt >= useLim && !mstGnt && mstBoundary
          && !p.useDone) begin
        pNxt.endTen = 1'b1;
        pNxt.useDone = 1'b1;
      end
    end

    // Prefetched word count; a fill adds a cache line
    pfAfter = p.pfCnt + (pfFill ? LINE_WORDS : 6'h0)
              - (pfConsume ? 6'h1 : 6'h0);
    pNxt.pfCnt = pfAfter;
    if (pfConsume && pfAfter == {2'h0, thr}) begin
      pNxt.rdReq = 1'b1;
    end

    // IDE sector tracking; prefetch never takes the last dword
    if (idePrefetch && p.pfOk) begin
      pNxt.idePf = p.idePf + 12'h1;
    end
    if (ideRead) begin
      if (p.ideWait) begin
        pNxt.ideWait = 1'b0;
        pNxt.idePf = 12'h1;
        pNxt.ideRd = 12'h1;
      end else if (p.ideRd + 12'h1 == secDw) begin
        pNxt.ideRd = 12'h0;
        pNxt.ideWait = 1'b1;
      end else begin
        pNxt.ideRd = p.ideRd + 12'h1;
      end
    end
    pNxt.pfOk = (secDw != 12'h0) && (pNxt.idePf < lastPf);

    // Activity seen by the clock-gating logic
    pNxt.busy = (pNxt.st != TS_IDLE) | mstTenure;
  end

  always_ff @(posedge pciClk or negedge rst_n) begin
    if (!rst_n) begin
      p <= '{st: TS_IDLE, default: '0};
    end else begin
      p <= pNxt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Checks on the PCI side
  chk_init_late:
  assert property (@(posedge pciClk) disable iff (!rst_n)
    (p.st == TS_FIRST && !tgtDataRdy && !tgtEnd
     && p.latCnt + 6'h1 == initLim) |=> tgtStop)
    else $error("first data late without stop");

  chk_subs_late:
  assert property (@(posedge pciClk) disable iff (!rst_n)
    (p.st == TS_BURST && !tgtDataRdy && !tgtEnd
     && p.latCnt + 6'h1 == subsLim) |=> tgtStop ##1 !tgtStop)
    else $error("burst data late without stop");

  chk_retry_abort:
  assert property (@(posedge pciClk) disable iff (!rst_n)
    mstAbort |-> $past(mstRetry) && $past(p.rty) == $past(rtyLim)
                 && $past(rtyLim) != 10'h0)
    else $error("abort not at retry limit");

  chk_retry_none:
  assert property (@(posedge pciClk) disable iff (!rst_n)
    (cfgHi[RTL_LSB +: 3] == 3'h0 && $stable(cfgHi)) |-> !mstAbort)
    else $error("abort with unlimited retries");

  chk_usage_end:
  assert property (@(posedge pciClk) disable iff (!rst_n)
    tenureEnd |-> $past(!mstGnt && mstBoundary && mstTenure
                        && p.useCnt >= useLim))
    else $error("tenure end without cause");

  chk_read_req:
  assert property (@(posedge pciClk) disable iff (!rst_n)
    (pfConsume && !pfFill && !flushActive
     && p.pfCnt == {2'h0, cfgHi[RTH_LSB +: 4]} + 6'h1) |=> readReq)
    else $error("read threshold missed");

  chk_ide_halt:
  assert property (@(posedge pciClk) disable iff (!rst_n)
    ($stable(cfgLo) && secDw != 12'h0 && p.idePf >= lastPf)
    |-> !idePrefetchOk)
    else $error("prefetch past sector end");

  chk_ide_off:
  assert property (@(posedge pciClk) disable iff (!rst_n)
    ($past(secDw) == 12'h0 && secDw == 12'h0) |-> !idePrefetchOk)
    else $error("prefetch with zero sector size");

  // Checks on the fabric side
  chk_rsvd_zero:
  assert property (@(posedge clk) disable iff (!rst_n)
    (addrPhase && !hwrite && reg_sel(haddr) == SEL_HI)
    |=> hrdata[23:20] == 4'h0 && hrdata[16:11] == 6'h0
        && hrdata[2:0] == 3'h0)
    else $error("reserved bits read nonzero");

  chk_sustain_hold:
  assert property (@(posedge clk) disable iff (!rst_n)
    ($fell(busyIn) && !s.bsySy[1] && s.ctlLo[SUS_LSB +: 3] == 3'h1)
    |-> clkRunReq [*4])
    else $error("clocks dropped before sustain");

  chk_sustain_none:
  assert property (@(posedge clk) disable iff (!rst_n)
    ($fell(busyIn) && !s.bsySy[1] && s.susCnt == 9'h0
     && s.ctlLo[SUS_LSB +: 3] == 3'h0) |=> !clkRunReq)
    else $error("sustain with code zero");

  cov_tgt_stop: cover property (@(posedge pciClk) disable iff (!rst_n)
    tgtStop);
  cov_abort: cover property (@(posedge pciClk) disable iff (!rst_n)
    mstAbort);
  cov_tenure: cover property (@(posedge pciClk) disable iff (!rst_n)
    tenureEnd);
  cov_ide_halt: cover property (@(posedge pciClk) disable iff (!rst_n)
    $fell(idePrefetchOk));

endmodule

// ===== pbtc_pkg.sv
// Shared constants, types and decoders of the bridge tuning controls
package pbtc_pkg;

  // Register byte offsets on the AHB-Lite slave
  localparam logic [11:0] CTRL_LO_OFS = 12'h000;
  localparam logic [11:0] CTRL_HI_OFS = 12'h004;
  localparam logic [11:0] STATUS_OFS = 12'h008;

  // Register selects
  localparam logic [1:0] SEL_LO = 2'h0;
  localparam logic [1:0] SEL_HI = 2'h1;
  localparam logic [1:0] SEL_STAT = 2'h2;
  localparam logic [1:0] SEL_NONE = 2'h3;

  // Reset values of the 64-bit control register, as two words
  localparam logic [31:0] CTRL_HI_RST = 32'h4400_0030;
  localparam logic [31:0] CTRL_LO_RST = 32'h0000_0003;

  // Implemented bits; everything else reads zero
  localparam logic [31:0] CTRL_HI_MASK = 32'hff0e_07f8;
  localparam logic [31:0] CTRL_LO_MASK = 32'hffe0_0000;

  // Field positions inside the high word
  localparam int FTH_LSB = 28;
  localparam int RTH_LSB = 24;
  localparam int RTL_LSB = 17;
  localparam int SUBSEQUENT_LATENCY_TIMEOUT_BIT = 10;
  localparam int INITIAL_LATENCY_TIMEOUT_LSB = 8;
  localparam int LAT_LSB = 3;
  // Field positions inside the low word
  localparam int SEC_LSB = 24;
  localparam int SUS_LSB = 21;

  // Timing and sizing counts
  localparam logic [9:0] RTL_BASE = 10'h008;
  localparam logic [8:0] SUS_BASE = 9'h004;
  localparam logic [5:0] INITIAL_LATENCY_TIMEOUT_MAX = 6'h20;
  localparam logic [5:0] SUBSEQUENT_LATENCY_TIMEOUT_SLOW = 6'h08;
  localparam logic [5:0] SUBSEQUENT_LATENCY_TIMEOUT_FAST = 6'h04;
  localparam logic [5:0] LINE_WORDS = 6'h08;

  // Inbound target latency states, Gray along the path
  typedef enum logic [1:0] {
    TS_IDLE = 2'h0,
    TS_FIRST = 2'h1,
    TS_BURST = 2'h3,
    TS_STOP = 2'h2
  } pbtc_tst_t;

  // Retry limit decode, zero means unlimited
  function automatic logic [9:0] pbtc_rty_lim(input logic [2:0] code);
    return (code == 3'h0) ? 10'h000 : RTL_BASE << (code - 3'h1);
  endfunction

  // Busy sustain decode in clock cycles
  function automatic logic [8:0] pbtc_sus_len(input logic [2:0] code);
    return (code == 3'h0) ? 9'h000 : SUS_BASE << (code - 3'h1);
  endfunction

endpackage

// ===== pbtc_cdc_word.sv
// Toggle handshake carrying a word from one clock domain to another
`timescale 1ns/1ps
module pbtc_cdc_word
  import pbtc_pkg::*;
#(
  parameter int W = 64,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic srcClk,
  input wire logic dstClk,
  input wire logic rst_n,
  input wire logic [W-1:0] srcData,
  output logic [W-1:0] dstData
);

  // Source side: held word, request toggle, ack synchroniser
  typedef struct packed {
    logic [W-1:0] sent;
    logic req;
    logic [1:0] ackSy;
  } pbtc_src_t;

  // Destination side: request synchroniser, ack toggle, copy
  typedef struct packed {
    logic [1:0] reqSy;
    logic ack;
    logic [W-1:0] data;
  } pbtc_dst_t;

  pbtc_src_t s, sNxt;
  pbtc_dst_t d, dNxt;

  ////////////////////////////////////////////////////////////////////
  // Source: resend whenever the word differs and no transfer flies
  always_comb begin
    sNxt = s;
    sNxt.ackSy = {s.ackSy[0], d.ack};
    if ((s.req == s.ackSy[1]) && (srcData != s.sent)) begin
      sNxt.sent = srcData;
      sNxt.req = ~s.req;
    end
  end

  always_ff @(posedge srcClk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '{sent: RST, req: 1'b0, ackSy: 2'h0};
    end else begin
      s <= sNxt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Destination: the held word is stable while the toggles differ
  always_comb begin
    dNxt = d;
    dNxt.reqSy = {d.reqSy[0], s.req};
    if (d.reqSy[1] != d.ack) begin
      dNxt.data = s.sent;
      dNxt.ack = d.reqSy[1];
    end
  end

  always_ff @(posedge dstClk or negedge rst_n) begin
    if (!rst_n) begin
      d <= '{reqSy: 2'h0, ack: 1'b0, data: RST};
    end else begin
      d <= dNxt;
    end
  end

  assign dstData = d.data;

endmodule

// ===== pbtc_pci_model.sv
// PCI-side partner: bus masters, targets and prefetch data stream
`timescale 1ns/1ps
module pbtc_pci_model (
  input wire logic pciClk,
  output logic tgtStart,
  output logic tgtDataRdy,
  output logic tgtEnd,
  output logic mstStart,
  output logic mstRetry,
  output logic mstDone,
  output logic mstTenure,
  output logic mstGnt,
  output logic mstBoundary,
  output logic pfFill,
  output logic pfConsume,
  output logic flushActive,
  output logic idePrefetch,
  output logic ideRead
);
  ////////////////////////////////////////////////////////////////////////
  // One bit per strobe or level, all idle at time zero
  logic [13:0] drvVec = 14'h0000;
  // Bit order matches the step masks of the bench
  assign {ideRead, idePrefetch, flushActive, pfConsume, pfFill, mstBoundary,
    mstGnt, mstTenure, mstDone, mstRetry, mstStart, tgtEnd, tgtDataRdy,
    tgtStart} = drvVec;
  ////////////////////////////////////////////////////////////////////////
  // One pciClk cycle of traffic; the caller then sees registered outputs
  // Slow answers are simply idle steps commanded by the bench
  task automatic step(input logic [13:0] v);
    @(posedge pciClk);
    drvVec <= v;
    #1;
  endtask
endmodule

// ===== test_pbtc_core.sv
// Self-checking bench of the bridge tuning controls
`timescale 1ns/1ps
module test_pbtc_core;
  import pbtc_pkg::*;
  // Step masks for the partner
  localparam logic [13:0] TS = 14'h0001;
  localparam logic [13:0] DR = 14'h0002;
  localparam logic [13:0] MS = 14'h0008;
  localparam logic [13:0] RT = 14'h0010;
  localparam logic [13:0] MD = 14'h0020;
  localparam logic [13:0] TEN = 14'h0040;
  localparam logic [13:0] GNT = 14'h0080;
  localparam logic [13:0] BND = 14'h0100;
  localparam logic [13:0] FIL = 14'h0200;
  localparam logic [13:0] CON = 14'h0400;
  localparam logic [13:0] FLU = 14'h0800;
  localparam logic [13:0] IPF = 14'h1000;
  localparam logic [13:0] IRD = 14'h2000;
  localparam logic [13:0] IDL = 14'h0000;
  logic clk = 1'b0;
  logic pciClk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic busyIn = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic hready, hreadyout, hresp, clkRunReq;
  logic [31:0] hrdata;
  logic tgtStart, tgtDataRdy, tgtEnd, tgtStop, mstStart, mstRetry, mstDone;
  logic mstAbort, mstTenure, mstGnt, mstBoundary, tenureEnd, pfFill;
  logic pfConsume, flushActive, readReq, idePrefetch, ideRead, idePrefetchOk;
  int err_total = 0;
  int cmp_count = 0;
  // Single slave: its ready is the bus ready
  assign hready = hreadyout;
  // Fabric clock 8 ns, link clock 125 ns, phases unrelated
  always #4 clk = ~clk;
  always #62.5 pciClk = ~pciClk;
  pbtc_core DUT (.clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready, .hreadyout, .hresp, .hrdata, .busyIn, .clkRunReq,
    .pciClk, .tgtStart, .tgtDataRdy, .tgtEnd, .tgtStop, .mstStart,
    .mstRetry, .mstDone, .mstAbort, .mstTenure, .mstGnt, .mstBoundary,
    .tenureEnd, .pfFill, .pfConsume, .flushActive, .readReq, .idePrefetch,
    .ideRead, .idePrefetchOk);
  pbtc_pci_model PM (.pciClk, .tgtStart, .tgtDataRdy, .tgtEnd, .mstStart,
    .mstRetry, .mstDone, .mstTenure, .mstGnt, .mstBoundary, .pfFill,
    .pfConsume, .flushActive, .idePrefetch, .ideRead);
  ////////////////////////////////////////////////////////////////////////
  // Count one comparison, report a mismatch at once
  task automatic chk(input logic ok, input string msg);
    cmp_count++;
    if (!ok) begin
      err_total++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask
  // One AHB-Lite single word transfer; waits on ready, unbounded
  task automatic ahb(input logic w, input logic [11:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {20'h00000, a};
    htrans <= 2'h2;
    hwrite <= w;
    // Only the watchdog ends a wait
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  // Write both words, then let the crossing settle
  task automatic cfg(input logic [31:0] hi, input logic [31:0] lo);
    logic [31:0] d;
    ahb(1'b1, CTRL_HI_OFS, hi, d);
    ahb(1'b1, CTRL_LO_OFS, lo, d);
    repeat (10) PM.step(IDL);
  endtask
  // High word from its fields
  function automatic logic [31:0] hw(input logic [3:0] f, input logic [3:0] r,
    input logic [2:0] rl, input logic s, input logic [1:0] il,
    input logic [4:0] lt);
    return (32'(f) << FTH_LSB) | (32'(r) << RTH_LSB) | (32'(rl) << RTL_LSB)
      | (32'(s) << SUBSEQUENT_LATENCY_TIMEOUT_BIT) | (32'(il) << INITIAL_LATENCY_TIMEOUT_LSB) | (32'(lt) << LAT_LSB);
  endfunction
  ////////////////////////////////////////////////////////////////////////
  // High word reset value, reserved bits, unmapped place
  task automatic t_regs();
    logic [31:0] d;
    ahb(1'b0, CTRL_HI_OFS, 32'h0, d);
    chk(d === CTRL_HI_RST, "high word reset");
    ahb(1'b1, CTRL_HI_OFS, 32'hffff_ffff, d);
    ahb(1'b0, CTRL_HI_OFS, 32'h0, d);
    chk(d === CTRL_HI_MASK, "high word reserved bits");
    ahb(1'b1, CTRL_LO_OFS, 32'hffff_ffff, d);
    ahb(1'b0, CTRL_LO_OFS, 32'h0, d);
    chk(d === CTRL_LO_MASK, "low word reserved bits");
    ahb(1'b1, 12'h00c, 32'hffff_ffff, d);
    ahb(1'b0, 12'h00c, 32'h0, d);
    chk(d === 32'h0000_0000, "unmapped read");
  endtask
  // Initial codes 0..3, then subsequent bit 0 and 1
  task automatic t_lat();
    int n;
    for (int c = 0; c < 6; c++) begin
      cfg(hw(4'h0, 4'h0, 3'h0, c[0], c[1:0], 5'h00), 32'h0);
      PM.step(TS);
      if (c > 3) PM.step(DR);
      n = -1;
      do begin
        PM.step(IDL);
        n++;
      end while (tgtStop !== 1'b1 && n < 40);
      chk(n == ((c < 4) ? (32 >> c) : (24 - 4 * c)), "late data stop");
      PM.step(IDL);
      chk(tgtStop === 1'b0, "stop lasts one cycle");
    end
  endtask
  // Every retry code: no abort up to the limit, abort one past it
  task automatic t_retry();
    logic seen;
    int lim;
    for (int c = 0; c < 8; c++) begin
      cfg(hw(4'h0, 4'h0, c[2:0], 1'b0, 2'h0, 5'h00), 32'h0);
      lim = (c == 0) ? 520 : (8 << (c - 1));
      seen = 1'b0;
      PM.step(MS);
      repeat (lim + 1) begin
        PM.step((lim > 0) ? RT : IDL);
        seen |= (mstAbort === 1'b1);
        lim--;
      end
      chk(!seen, "abort too early");
      if (c > 0) begin
        PM.step(RT);
        PM.step(IDL);
        chk(mstAbort === 1'b1, "abort past limit");
      end
      PM.step(MD);
    end
  endtask
  // Usage time-out of 2 units: held off by grant, then once per tenure
  task automatic t_usage();
    int n;
    cfg(hw(4'h0, 4'h0, 3'h0, 1'b0, 2'h0, 5'h02), 32'h0);
    n = 0;
    repeat (30) begin
      PM.step(TEN | GNT | BND);
      if (tenureEnd === 1'b1) n++;
    end
    repeat (4) begin
      PM.step(TEN | BND);
      if (tenureEnd === 1'b1) n++;
    end
    chk(n == 1, "one end after grant drops");
    repeat (2) PM.step(IDL);
    n = 0;
    do begin
      PM.step(TEN | BND);
      n++;
    end while (tenureEnd !== 1'b1 && n < 40);
    chk(n >= 15 && n <= 18, "usage expiry in eight-clock units");
    PM.step(IDL);
  endtask
  // One line in, consume; request when the count meets the threshold
  task automatic t_pf(input logic fl, input logic [3:0] th);
    int first;
    first = 0;
    cfg(hw(fl ? th : 4'h1, fl ? 4'h1 : th, 3'h0, 1'b0, 2'h0, 5'h00), 32'h0);
    PM.step(FIL);
    for (int k = 1; k < 10; k++) begin
      PM.step((k < 9) ? (CON | (fl ? FLU : IDL)) : IDL);
      if (readReq === 1'b1 && first == 0) first = k;
    end
    chk(first == 9 - int'(th), "prefetch request point");
  endtask
  // Sector sizes 1 and 2 units: halt early, resume in next sector
  task automatic t_ide();
    // A resume leaves both counts at one, so later sizes start there
    for (int s = 1; s < 3; s++) begin
      cfg(32'h0, 32'(s) << SEC_LSB);
      repeat (16 * s - 2 - (s - 1)) PM.step(IPF);
      repeat (2) PM.step(IDL);
      chk(idePrefetchOk === 1'b1, "prefetch open");
      PM.step(IPF);
      repeat (2) PM.step(IDL);
      chk(idePrefetchOk === 1'b0, "halt one dword early");
      repeat (16 * s - (s - 1)) PM.step(IRD);
      repeat (2) PM.step(IDL);
      chk(idePrefetchOk === 1'b0, "still halted in sector");
      PM.step(IRD);
      repeat (2) PM.step(IDL);
      chk(idePrefetchOk === 1'b1, "resume in next sector");
    end
    cfg(32'h0, 32'h0);
    chk(idePrefetchOk === 1'b0, "size zero never prefetches");
  endtask
  // Every sustain code: clocks held the decoded span after busy
  task automatic t_sus();
    int n;
    int len;
    for (int c = 0; c < 8; c++) begin
      cfg(32'h0, 32'(c) << SUS_LSB);
      len = (c == 0) ? 0 : (4 << (c - 1));
      @(posedge clk);
      busyIn <= 1'b1;
      repeat (3) @(posedge clk);
      #1;
      chk(clkRunReq === 1'b1, "clocks run while busy");
      @(posedge clk);
      busyIn <= 1'b0;
      n = 0;
      do begin
        @(posedge clk);
        #1;
        n++;
      end while (clkRunReq === 1'b1 && n < 300);
      chk(n >= len + 1 && n <= len + 2, "busy sustain span");
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Verdict, reached from the main sequence or the watchdog
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Reset spans five fabric clocks and two link clocks
  initial begin
    repeat (5) @(posedge clk);
    repeat (2) @(posedge pciClk);
    @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_lat();
    t_retry();
    t_usage();
    t_pf(1'b0, 4'h5);
    t_pf(1'b1, 4'h2);
    t_ide();
    t_sus();
    final_report();
  end
  // Watchdog: the full run needs well under half this span
  initial begin
    #700000;
    err_total++;
    final_report();
  end
endmodule
